// ==== logic/psa_ctrl.sv ====
// Top of the passing speed allowance controller: pedal arming, pass
// metering, warning lamp and cap rampdown.
// Assumes speed and caps in the same unit; pedal and midnight pins synchronised here.
`timescale 1ns/1ps
`default_nettype none
module psa_ctrl #(
  parameter int unsigned TICK_CYCLES = psa_pkg::TickCycles,
  parameter int unsigned SPEED_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic pedalFull,
  input wire logic pedalReleased,
  input wire logic cruiseActive,
  input wire logic [SPEED_W-1:0] vehicleSpeed,
  input wire logic [SPEED_W-1:0] normalCap,
  input wire logic activeFault,
  input wire logic stopEngineFault,
  input wire logic midnight,
  input wire logic programStrobe,
  input wire logic [7:0] budgetMinutes,
  input wire logic [4:0] budgetResetPeriod,
  input wire logic [7:0] extraSpeedMargin,
  output logic [SPEED_W-1:0] roadSpeedCap,
  output logic warningLamp,
  output logic passActive,
  output logic cruiseKeep
);
  import psa_pkg::*;

  // Elaboration checks on the parameters
  if (SPEED_W < 8) begin : gBadSpeedW
    $error("psa_ctrl SPEED_W below margin width");
  end
  if (TICK_CYCLES < 2) begin : gBadTick
    $error("psa_ctrl TICK_CYCLES too small");
  end

  // Synchronised pins
  logic fullS;
  logic relS;
  logic midS;
  logic midPrev_q;
  // Second tick
  logic sec;
  // Programmed settings
  logic [7:0] budgetSet_q;
  logic [4:0] period_q;
  logic [7:0] margin_q;
  // Remaining pass time in seconds
  logic [15:0] remain_q;
  // Seconds into the current reset period
  logic [16:0] perSec_q;
  // Pump window and generic state timer
  logic [4:0] pumpSec_q;
  logic [4:0] stSec_q;
  logic [2:0] rampSec_q;
  psa_pump_t pump_q;
  psa_state_t st_q;
  logic flash_q;
  logic armPulse;
  // Second release seen within the pump sequence
  logic pumpSecondRel_q;

  // Pin synchronisers
  psa_sync uSyncFull (.clock(clock), .rst_b(rst_b), .ce(ce), .pinIn(pedalFull),
    .syncOut(fullS));
  psa_sync uSyncRel (.clock(clock), .rst_b(rst_b), .ce(ce), .pinIn(pedalReleased),
    .syncOut(relS));
  psa_sync uSyncMid (.clock(clock), .rst_b(rst_b), .ce(ce), .pinIn(midnight),
    .syncOut(midS));

  psa_tick #(.DIV(TICK_CYCLES)) uTick (.clock(clock), .rst_b(rst_b), .ce(ce),
    .restart(programStrobe), .tick(sec));

  // Period classification, used once
  function automatic logic isAligned(input logic [4:0] p);
    isAligned = (p == PeriodA) || (p == PeriodB) || (p == PeriodC);
  endfunction : isAligned

  // Decoded conditions
  wire aboveCap = vehicleSpeed > normalCap;
  wire midEdge = midS && !midPrev_q;
  wire [16:0] periodSecs = 17'(period_q * SecPerHour);
  wire periodEnd = sec && (perSec_q + 17'h1 >= periodSecs);
  wire midRefill = midEdge && isAligned(period_q);
  // other periods refill only by count
  wire refill = periodEnd || midRefill;
  wire featureOn = (budgetSet_q != 8'h00) && (margin_q != 8'h00);
  wire budgetLeft = remain_q != 16'h0;
  wire warnZone = remain_q <= 16'(WarnSec);
  wire [SPEED_W-1:0] raisedCap = normalCap + SPEED_W'(margin_q);
  wire [SPEED_W-1:0] rampStep = SPEED_W'(margin_q * rampSec_q / RampSec);
  wire [15:0] fullBudget = 16'(budgetSet_q * SecPerMin);

  // Settings, latched on programming
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      budgetSet_q <= BudgetReset;
      period_q <= PeriodReset;
      margin_q <= MarginReset;
      midPrev_q <= 1'b0;
    end else if (ce) begin
      midPrev_q <= midS;
      if (programStrobe) begin
        budgetSet_q <= budgetMinutes;
        period_q <= budgetResetPeriod;
        margin_q <= extraSpeedMargin;
      end
    end
  end

  // Reset period timer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      perSec_q <= 17'h0;
    end else if (ce) begin
      if (programStrobe || periodEnd) perSec_q <= 17'h0;
      else if (sec) perSec_q <= perSec_q + 17'h1;
    end
  end

  // Pump window expired; final full press after the second release
  wire pumpLate = (pump_q != PumpIdle) && (pumpSec_q >= 5'(ArmWindowSec));
  wire pumpArm = fullS && pumpSecondRel_q;

  // Pump detector: full, release, full, release, full
  // foot pedal inputs only arm
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pump_q <= PumpIdle;
      pumpSec_q <= 5'h0;
      armPulse <= 1'b0;
    end else if (ce) begin
      armPulse <= 1'b0;
      // Seconds since the first full press
      if (pump_q == PumpIdle) pumpSec_q <= 5'h0;
      else if (sec) pumpSec_q <= pumpSec_q + 5'h1;
      if (pumpLate) begin
        pump_q <= PumpIdle;
      end else begin
        case (pump_q)
          // Waiting for the first full press
          PumpIdle: if (fullS) pump_q <= PumpRel1;
          // Waiting for the first release
          PumpRel1: if (relS) pump_q <= PumpFull1;
          // Waiting for the second full press
          PumpFull1: if (fullS) pump_q <= PumpRel2;
          // Second release is marked aside; final full arms
          PumpRel2: begin
            if (pumpArm) begin
              armPulse <= 1'b1;
              pump_q <= PumpIdle;
            end
          end
          default: pump_q <= PumpIdle;
        endcase
      end
    end
  end

  // Marks the second release seen within the pump sequence
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pumpSecondRel_q <= 1'b0;
    else if (ce) begin
      if (pump_q == PumpIdle) pumpSecondRel_q <= 1'b0;
      else if (pump_q == PumpRel2 && relS) pumpSecondRel_q <= 1'b1;
    end
  end

  // Main pass state machine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= PsIdle;
      stSec_q <= 5'h0;
      rampSec_q <= 3'h0;
      remain_q <= 16'h0;
    end else if (ce) begin
      if (sec) stSec_q <= stSec_q + 5'h1;
      if (refill) remain_q <= fullBudget;
      else if (programStrobe) remain_q <= 16'(budgetMinutes * SecPerMin);
      else if (sec && aboveCap && (st_q == PsPass) && budgetLeft)
        remain_q <= remain_q - 16'h1;
      case (st_q)
        PsIdle: begin
          stSec_q <= 5'h0;
          if (armPulse && featureOn && budgetLeft && !stopEngineFault) st_q <= PsArmed;
        end
        PsArmed: begin
          if (stopEngineFault) st_q <= PsIdle;
          else if (aboveCap) st_q <= PsPass;
          else if (stSec_q >= 5'(AccelWindowSec)) st_q <= PsIdle;
        end
        PsPass: begin
          rampSec_q <= 3'h0;
          if (stopEngineFault || !aboveCap) st_q <= PsIdle;
          else if (!budgetLeft) st_q <= PsRamp;
        end
        PsRamp: begin
          if (sec) rampSec_q <= rampSec_q + 3'h1;
          if (stopEngineFault) st_q <= PsIdle;
          else if (sec && rampSec_q + 3'h1 >= 3'(RampSec)) st_q <= PsSpent;
        end
        PsSpent: begin
          if (budgetLeft || !aboveCap) st_q <= PsIdle;
        end
        default: st_q <= PsIdle;
      endcase
    end
  end

  // Lamp flash phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) flash_q <= 1'b0;
    else if (ce && sec) flash_q <= !flash_q;
  end

  // Output selection
  // raised cap when passing
  wire [SPEED_W-1:0] capD = (st_q == PsPass && !stopEngineFault) ? raisedCap :
                            (st_q == PsRamp && !stopEngineFault) ? raisedCap - rampStep :
                            normalCap;
  wire warnOn = (st_q == PsPass && warnZone) || st_q == PsRamp;
  wire lampD = warnOn ? flash_q : activeFault;

  // Registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      roadSpeedCap <= '0;
      warningLamp <= 1'b0;
      passActive <= 1'b0;
      cruiseKeep <= 1'b0;
    end else if (ce) begin
      roadSpeedCap <= capD;
      warningLamp <= lampD;
      passActive <= st_q == PsPass || st_q == PsRamp;
      cruiseKeep <= cruiseActive;
    end
  end

  // Assertions
  // stop fault keeps normal cap
  stop_fault_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && stopEngineFault |=> roadSpeedCap == $past(normalCap))
    else $error("cap raised during stop fault");
  drop_disarm_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && st_q == PsPass && !aboveCap |=> st_q == PsIdle)
    else $error("pass not ended on speed drop");
  budget_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && !aboveCap && !refill && !programStrobe |=> remain_q == $past(remain_q))
    else $error("budget moved below cap");
  arm_lapse_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == PsArmed |-> stSec_q <= 5'(AccelWindowSec))
    else $error("arming window overran");
  ramp_len_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == PsRamp |-> rampSec_q < 3'(RampSec))
    else $error("rampdown overran");
  raised_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && st_q == PsPass && !stopEngineFault |=> roadSpeedCap == $past(raisedCap))
    else $error("raised cap wrong");
  fault_lamp_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && st_q == PsIdle && activeFault |=> warningLamp)
    else $error("fault lamp not steady");
  spent_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && st_q == PsSpent |=> roadSpeedCap == $past(normalCap))
    else $error("cap raised after budget spent");
  // Named steps: an accepted pump, and a spent budget while passing
  sequence armAccept_s;
    ce && st_q == PsIdle && armPulse && featureOn && budgetLeft && !stopEngineFault;
  endsequence : armAccept_s
  sequence budgetGone_s;
    ce && st_q == PsPass && aboveCap && !budgetLeft && !stopEngineFault;
  endsequence : budgetGone_s
  arm_accept_a: assert property (@(posedge clock) disable iff (!rst_b)
    armAccept_s |=> st_q == PsArmed)
    else $error("accepted pump did not arm");
  arm_order_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && armPulse |-> $past(pumpSecondRel_q))
    else $error("arm without second release");
  ramp_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    budgetGone_s |=> st_q == PsRamp)
    else $error("rampdown not started");
endmodule : psa_ctrl
`default_nettype wire

// ==== inc/psa_pkg.sv ====
// Constants for the passing speed allowance controller.
// Assumes a single 40 MHz clock and that all control inputs are plain ports.
package psa_pkg;
  localparam int unsigned ClockHz = 40_000_000;
  localparam int unsigned TickSec = 1;
  localparam int unsigned TickCycles = ClockHz * TickSec;
  localparam int unsigned ArmWindowSec = 5;
  localparam int unsigned AccelWindowSec = 20;
  localparam int unsigned WarnSec = 60;
  localparam int unsigned RampSec = 5;
  localparam int unsigned SecPerMin = 60;
  localparam int unsigned SecPerHour = 3600;
  localparam int unsigned FlashHalfSec = 1;
  localparam logic [4:0] PeriodA = 5'h08;
  localparam logic [4:0] PeriodB = 5'h0c;
  localparam logic [4:0] PeriodC = 5'h18;
  localparam logic [4:0] PeriodReset = 5'h08;
  localparam logic [7:0] BudgetReset = 8'h00;
  localparam logic [7:0] MarginReset = 8'h00;
  typedef enum logic [3:0] {
    PumpIdle = 4'b0001,
    PumpRel1 = 4'b0010,
    PumpFull1 = 4'b0100,
    PumpRel2 = 4'b1000
  } psa_pump_t;
  typedef enum logic [4:0] {
    PsIdle = 5'b00001,
    PsArmed = 5'b00010,
    PsPass = 5'b00100,
    PsRamp = 5'b01000,
    PsSpent = 5'b10000
  } psa_state_t;
endpackage : psa_pkg

// ==== logic/psa_tick.sv ====
// Divider that gives a one-cycle pulse every DIV enabled cycles.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module psa_tick #(
  parameter int unsigned DIV = 40_000_000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic restart,
  output logic tick
);
  // Divider counter
  logic [31:0] cnt_q;
  // Elaboration check on the divider
  if (DIV < 2) begin : gBadDiv
    $error("psa_tick DIV too small");
  end
  // Count and wrap, restart aligns the phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        cnt_q <= 32'h0;
      end else if (cnt_q == 32'(DIV - 1)) begin
        cnt_q <= 32'h0;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule : psa_tick
`default_nettype wire

// ==== logic/psa_sync.sv ====
// Three-stage synchroniser; output changes once stages two and three agree.
// Assumes an asynchronous pin source and one clock.
`timescale 1ns/1ps
`default_nettype none
module psa_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic pinIn,
  output logic syncOut
);
  // Shift stages
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Capture and filter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      syncOut <= 1'b0;
    end else if (ce) begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) syncOut <= s3_q;
    end
  end
endmodule : psa_sync
`default_nettype wire

// ==== sim/psa_pedal_model.sv ====
// Model of the foot pedal and vehicle speed source in front of the controller.
// Assumes the bench clock; drives only on falling edges.
`timescale 1ns/1ps
`default_nettype none
module psa_pedal_model (
  input wire logic clock,
  output logic pedalFull,
  output logic pedalReleased,
  output logic [7:0] vehicleSpeed
);
  // Pedal mid travel, vehicle stopped
  initial begin
    pedalFull = 1'b0;
    pedalReleased = 1'b0;
    vehicleSpeed = 8'h00;
  end
  // full, released, full, released, full by foot
  task automatic pump(input int n);
    for (int i = 0; i < 5; i++) begin
      pedalFull = 1'b0;
      pedalReleased = 1'b0;
      repeat (2) @(negedge clock);
      pedalFull = (i % 2 == 0);
      pedalReleased = (i % 2 != 0);
      repeat (n) @(negedge clock);
    end
    // Foot back to mid travel once the pump is done
    pedalFull = 1'b0;
    pedalReleased = 1'b0;
  endtask : pump
  task automatic set_speed(input logic [7:0] s);
    @(negedge clock);
    vehicleSpeed = s;
  endtask : set_speed
endmodule : psa_pedal_model
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the passing speed allowance controller.
// Assumes the pedal model drives pedal and speed pins; one second is Tk cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psa_pkg::*;
  localparam int Tk = 8; // Cycles per second
  localparam logic [7:0] Norm = 8'h64; // Normal cap
  logic clock, rst_b, cruiseActive, activeFault, stopEngineFault, midnight, programStrobe;
  logic pedalFull, pedalReleased, warningLamp, passActive, cruiseKeep;
  logic [7:0] margin, budgetMinutes, roadSpeedCap, vehicleSpeed;
  logic [4:0] budgetResetPeriod;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0; // Cycle count
  int p0 = 0; // Cycle of last programming
  logic [9:0] expQ[$]; // Notes of {passActive, cruiseKeep, cap}
  event sampleEv;
  // Clock, 25 ns
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  psa_pedal_model i_psa_pedal_model (.clock(clock), .pedalFull(pedalFull),
    .pedalReleased(pedalReleased), .vehicleSpeed(vehicleSpeed));
  psa_ctrl #(.TICK_CYCLES(Tk), .SPEED_W(8)) i_psa_ctrl (.clock(clock), .rst_b(rst_b),
    .ce(1'b1), .pedalFull(pedalFull), .pedalReleased(pedalReleased),
    .cruiseActive(cruiseActive), .vehicleSpeed(vehicleSpeed), .normalCap(Norm),
    .activeFault(activeFault), .stopEngineFault(stopEngineFault), .midnight(midnight),
    .programStrobe(programStrobe), .budgetMinutes(budgetMinutes),
    .budgetResetPeriod(budgetResetPeriod), .extraSpeedMargin(margin),
    .roadSpeedCap(roadSpeedCap), .warningLamp(warningLamp), .passActive(passActive),
    .cruiseKeep(cruiseKeep));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Oldest note against outputs
  initial forever begin
    @(sampleEv);
    check({passActive, cruiseKeep, roadSpeedCap}, expQ.pop_front());
  end
  // Note expectation after outputs settle
  task automatic expect_out(input logic pa, input logic [7:0] cap);
    repeat (12) @(negedge clock);
    expQ.push_back({pa, cruiseActive, cap});
    ->sampleEv;
  endtask : expect_out
  task automatic program_cfg(input logic [4:0] per);
    budgetResetPeriod = per;
    programStrobe = 1'b1;
    @(negedge clock);
    programStrobe = 1'b0;
    p0 = cyc;
  endtask : program_cfg
  // Pump then go above normal cap after a delay in seconds
  task automatic go(input int n, input int sec);
    i_psa_pedal_model.set_speed(Norm - 8'h01);
    cruiseActive = 1'($urandom_range(1));
    // Let any unfinished pump window lapse first
    repeat (6 * Tk) @(negedge clock);
    i_psa_pedal_model.pump(n);
    repeat (sec * Tk) @(negedge clock);
    i_psa_pedal_model.set_speed(Norm + 8'h01);
  endtask : go
  task automatic pulse_midnight();
    midnight = 1'b1;
    repeat (6) @(negedge clock);
    midnight = 1'b0;
  endtask : pulse_midnight
  // Use up the budget, timing warning and rampdown
  task automatic run_out();
    int t0, tg, flips;
    logic lampWas;
    t0 = -1;
    tg = 0;
    flips = 0;
    go(3, 0);
    repeat (12) @(negedge clock);
    lampWas = warningLamp;
    for (int c = 0; c < 900 && passActive === 1'b1; c++) begin
      @(negedge clock);
      if (warningLamp !== lampWas && t0 < 0) flips++;
      lampWas = warningLamp;
      if (roadSpeedCap !== Norm + margin && t0 < 0) t0 = c;
      tg = c;
    end
    check(16'(flips >= 8), 16'h0001);
    check(16'(tg - t0 >= 3 * Tk && tg - t0 <= 5 * Tk + 2), 16'h0001);
    expect_out(1'b0, Norm);
    check(16'(warningLamp), 16'(activeFault));
  endtask : run_out
  task automatic end_sim();
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    repeat (45000) @(posedge clock);
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h6abef6cc));
    {rst_b, cruiseActive, activeFault, stopEngineFault, midnight, programStrobe} = 6'h00;
    budgetMinutes = 8'h01;
    budgetResetPeriod = 5'h08;
    margin = 8'h0a + 8'($urandom_range(40));
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    program_cfg(5'h08);
    for (int i = 0; i < 2; i++) begin
      go(3, 0);
      expect_out(1'b1, Norm + margin);
      i_psa_pedal_model.set_speed(Norm - 8'h01);
      expect_out(1'b0, Norm);
    end
    $display("Test arm and pass done");
    go(10, 0);
    expect_out(1'b0, Norm);
    go(3, 21);
    expect_out(1'b0, Norm);
    stopEngineFault = 1'b1;
    go(3, 0);
    expect_out(1'b0, Norm);
    stopEngineFault = 1'b0;
    $display("Test refusals done");
    activeFault = 1'b1;
    repeat (12) @(negedge clock);
    check(16'(warningLamp), 16'h0001);
    run_out();
    go(3, 0);
    expect_out(1'b0, Norm);
    activeFault = 1'b0;
    i_psa_pedal_model.set_speed(Norm - 8'h01);
    pulse_midnight();
    go(3, 0);
    expect_out(1'b1, Norm + margin);
    $display("Test budget and midnight done");
    program_cfg(5'h01);
    run_out();
    i_psa_pedal_model.set_speed(Norm - 8'h01);
    pulse_midnight();
    go(3, 0);
    expect_out(1'b0, Norm);
    while (cyc - p0 < 3600 * Tk + Tk) @(negedge clock);
    go(3, 0);
    expect_out(1'b1, Norm + margin);
    $display("Test free period done");
    repeat (4) @(negedge clock);
    end_sim();
  end
endmodule : tb
`default_nettype wire
